// File: inc/glpc_defs.svh
/*
 * Register offsets, field positions, reset values and timing figures of the port and
 * LED block. Included by its bare name from the core.
 */
`ifndef GLPC_DEFS_SVH
`define GLPC_DEFS_SVH
`define GLPC_A_LEDEN    8'h31
`define GLPC_A_ROWDIR   8'h34
`define GLPC_A_COLDIR   8'h35
`define GLPC_A_ROWDRV   8'h36
`define GLPC_A_COLDRV   8'h37
`define GLPC_A_ROWREF   8'h38
`define GLPC_A_COLREF   8'h39
`define GLPC_A_ROWVAL   8'h3A
`define GLPC_A_COLVAL   8'h3B
`define GLPC_A_XLATE    8'h3C
`define GLPC_A_GCTL     8'h40
`define GLPC_A_DBNC     8'h42
`define GLPC_A_SINK     8'h43
`define GLPC_A_SHARED   8'h45
`define GLPC_A_TOFLAG   8'h48
`define GLPC_A_INT4     8'h50
`define GLPC_A_INT7     8'h53
`define GLPC_A_CFG4     8'h54
`define GLPC_A_CFG7     8'h57
`define GLPC_A_ROWMSK   8'h58
`define GLPC_A_COLMSK   8'h59
`define GLPC_A_ROWEDG   8'h5A
`define GLPC_A_COLEDG   8'h5B
`define GLPC_B_TOIE     5
`define GLPC_B_GEN      4
`define GLPC_B_SRST     3
`define GLPC_B_SHARED   5
`define GLPC_RST_REG    8'h00
`define GLPC_CLK_NS     40
`define GLPC_MS_NS      1000000
`define GLPC_MS_CYC     (`GLPC_MS_NS / `GLPC_CLK_NS)
`define GLPC_PWM_STEP   98
`define GLPC_DB_MIN_MS  6'h09
`define GLPC_FADE_STEPS 5'h10
`define GLPC_FADE_MS    12'h010
`define GLPC_BLINK_MS   13'h0100
`endif

// File: inc/glpc_pkg.sv
/*
 * Types of the port and LED block: fade modes and the packed state of the core.
 * Uses nothing from the defs header.
 */
package glpc_pkg;
    typedef enum logic [1:0] {
        FADE_NONE = 2'b00,
        FADE_IN   = 2'b01,
        FADE_OUT  = 2'b10
    } glpc_fade_e;

    typedef struct packed {
        logic [7:0]            rowDrv, colDrv, rowRef, colRef, rowDir, colDir, xlate;
        logic [3:0]            ledEn;
        logic [5:0]            gctl;
        logic [4:0]            dbSel;
        logic                  sinkSel;
        logic [7:0]            shared;
        logic [3:0][7:0]       indiv;
        logic [3:0][5:0]       ledCfg;
        logic [7:0]            rowMask, colMask, rowEdge, colEdge;
        logic [15:0]           outVal, sync1, sync2, stable, snap, busy, settled;
        logic [15:0][5:0]      dbCnt;
        logic                  portIrq, toFlag, asleep;
        logic [15:0]           msCnt;
        logic                  msTick;
        logic [7:0]            stepCnt, pwmCnt;
        logic [11:0]           blinkCnt, fadeCnt;
        logic [3:0][7:0]       duty, fBase;
        glpc_fade_e [3:0]      fMode;
        logic [3:0][4:0]       fStep;
        logic [3:0]            dark;
        logic [7:0]            rdData;
        logic [7:0]            rowOut, rowOeN, colOut, colOeN;
    } glpc_state_s;
endpackage

// File: rtl/glpc_core.sv
/*
 * Sixteen general ports with debounce, edge events, level translators and four
 * PWM LED drivers with blink and fade, behind the register port of the serial slave.
 * Assumes the serial engine runs on ref_clk and gives one-cycle read and write strobes.
 */
// Behaviour
// - Output-mode bit 0 drives open-drain, 1 drives push-pull, per port.
// - Supply-select bit picks main supply at 0, alternate logic rail at 1.
// - Value registers hold debounced levels; a new input waits one debounce period.
// - Written value sets output level; outputs read back as zero.
// - Translator bit n links column n and row n; column direction picks way.
// - Global control: bus-timeout interrupt enable, port enable, soft reset.
// - Five-bit field selects 32 debounce times from 9 ms to 40 ms.
// - Bit 0 picks low or high sink current for LED ports only.
// - Intensity 0x00-0xFE sinks that many of 256 steps; 0xFF sinks always.
// - New intensity takes effect at the next PWM cycle start, or at once when written during a fade-in; a new shared value takes effect one cycle later.
// - Bit 5 of LED setup picks shared or individual intensity.
// - Bits 4:2 choose blink period, bits 1:0 choose blink on-time.
// - Timeout flag in bit 0; reading it clears the timeout interrupt.
// - Mask bit 0 lets port events raise the interrupt, 1 blocks them.
// - Port interrupt stays until value registers are read; later events only update.
// - Events during a serial read are held and latched after it.
// - Events only on inputs; edge bit 0 rising only, 1 both edges.
// - Level sampled at transition and after debounce time; stable unmasked raises event.
// - Sleep is refused while ports or LEDs enabled; sleep stops the timers.
// - Non-zero fade time enables 16-step fades in and out.
// - Shared intensity to or from zero fades shared-intensity ports out or in.
// - Waking fades LEDs in; intensity write during fade-in outputs it at once.
// - Sleeping fades LEDs out; intensity write during fade-out turns port off.
// - Blink periods 256 ms to 4.096 s; on-time 50, 25, 12.5, 6.25 percent.
// - Shared-intensity ports copy the shared value at each PWM cycle start.
`timescale 1ns/1ps
`include "glpc_defs.svh"
module glpc_core #(
    parameter int         CYC_PER_MS   = `GLPC_MS_CYC,
    parameter logic [7:0] PWM_STEP_CYC = 8'(`GLPC_PWM_STEP)
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    input  wire logic       serialReadActive,
    input  wire logic       busTimeout,
    input  wire logic       sleepRequest,
    output logic            sleepActive,
    input  wire logic [7:0] rowIn,
    input  wire logic [7:0] colIn,
    output logic      [7:0] rowOut,
    output logic      [7:0] rowOe_n,
    output logic      [7:0] colOut,
    output logic      [7:0] colOe_n,
    output logic      [7:0] rowRefAlt,
    output logic      [7:0] colRefAlt,
    output logic            sinkHigh,
    output logic            interruptReq
);
    glpc_pkg::glpc_state_s st_r;
    glpc_pkg::glpc_state_s st_nxt;

    function automatic logic [7:0] scale(input logic [7:0] base, input logic [4:0] step);
        logic [12:0] p;
        p = base * step;
        return p[11:4];
    endfunction

    always_comb begin
        logic [15:0] dir, isOut, drv, lvl, edgeSel, mask, drvVal;
        logic [5:0]  dbLen;
        logic [2:0]  fSh, bSh;
        logic [11:0] fLim, phase;
        logic [12:0] per, onLen;
        logic        stepTick, pwmStart, fadeTick, wake, sleepNow, gEn, rdVal;
        logic        trigIn, trigOut, sinkOn, blinkOn;
        int          k;
        {dir, isOut, drv, lvl, edgeSel, mask, drvVal} = '0;
        {dbLen, fSh, bSh, fLim, phase, per, onLen} = '0;
        {stepTick, pwmStart, fadeTick, wake, sleepNow, gEn, rdVal} = '0;
        {trigIn, trigOut, sinkOn, blinkOn} = '0;
        k = 0;
        st_nxt = st_r;
        st_nxt.sync1 = {colIn, rowIn};
        st_nxt.sync2 = st_r.sync1;
        gEn = st_r.gctl[`GLPC_B_GEN];
        st_nxt.asleep = sleepRequest & ~gEn & ~(|st_r.ledEn);
        sleepNow = st_nxt.asleep & ~st_r.asleep;
        wake = ~st_nxt.asleep & st_r.asleep;
        st_nxt.msTick = 1'b0;
        stepTick = 1'b0;
        if (!st_r.asleep) begin
            st_nxt.msCnt = st_r.msCnt + 16'h0001;
            if (st_r.msCnt == 16'(CYC_PER_MS - 1)) begin
                st_nxt.msCnt = 16'h0000;
                st_nxt.msTick = 1'b1;
            end
            st_nxt.stepCnt = st_r.stepCnt + 8'h01;
            if (st_r.stepCnt == PWM_STEP_CYC - 8'h01) begin
                st_nxt.stepCnt = 8'h00;
                stepTick = 1'b1;
            end
        end
        if (stepTick) begin
            st_nxt.pwmCnt = st_r.pwmCnt + 8'h01;
        end
        pwmStart = stepTick & (st_r.pwmCnt == 8'hFF);
        if (st_r.msTick) begin
            st_nxt.blinkCnt = st_r.blinkCnt + 12'h001;
        end
        fSh = (st_r.gctl[2:0] > 3'h5) ? 3'h4 : st_r.gctl[2:0] - 3'h1;
        fLim = `GLPC_FADE_MS << fSh;
        fadeTick = 1'b0;
        if (st_r.msTick) begin
            st_nxt.fadeCnt = st_r.fadeCnt + 12'h001;
            if (st_nxt.fadeCnt >= fLim) begin
                st_nxt.fadeCnt = 12'h000;
                fadeTick = st_r.gctl[2:0] != 3'h0;
            end
        end
        // Timeout flag, set wins over read clear.
        if (regRdEn && regAddr == `GLPC_A_TOFLAG) begin
            st_nxt.toFlag = 1'b0;
        end
        if (busTimeout && !st_r.asleep) begin
            st_nxt.toFlag = 1'b1;
        end
        if (regRdEn && (regAddr == `GLPC_A_ROWVAL || regAddr == `GLPC_A_COLVAL)) begin
            st_nxt.portIrq = 1'b0;
        end
        dir = {st_r.colDir, st_r.rowDir};
        isOut = {st_r.xlate & st_r.colDir, st_r.xlate & ~st_r.colDir} | dir;
        isOut = isOut & ~{st_r.xlate & ~st_r.colDir, st_r.xlate & st_r.colDir};
        drv = {st_r.colDrv, st_r.rowDrv};
        lvl = st_r.sync2;
        drvVal = st_r.outVal;
        for (k = 0; k < 8; k++) begin
            if (st_r.xlate[k]) begin
                drvVal[k] = lvl[k + 8];
                drvVal[k + 8] = lvl[k];
            end
        end
        edgeSel = {st_r.colEdge, st_r.rowEdge};
        mask = {st_r.colMask, st_r.rowMask};
        dbLen = `GLPC_DB_MIN_MS + {1'b0, st_r.dbSel};
        for (k = 0; k < 16; k++) begin
            if (st_r.msTick && st_r.dbCnt[k] < dbLen) begin
                st_nxt.dbCnt[k] = st_r.dbCnt[k] + 6'h01;
            end
            if (isOut[k]) begin
                st_nxt.settled[k] = 1'b0;
                st_nxt.busy[k] = 1'b0;
                st_nxt.dbCnt[k] = 6'h00;
            end else if (!st_r.settled[k]) begin
                if (st_r.dbCnt[k] >= dbLen) begin
                    st_nxt.settled[k] = 1'b1;
                    st_nxt.stable[k] = lvl[k];
                end
            end else if (!st_r.busy[k]) begin
                if (lvl[k] != st_r.stable[k]) begin
                    st_nxt.busy[k] = 1'b1;
                    st_nxt.snap[k] = lvl[k];
                    st_nxt.dbCnt[k] = 6'h00;
                end
            end else if (st_r.dbCnt[k] >= dbLen) begin
                if (lvl[k] != st_r.snap[k]) begin
                    st_nxt.busy[k] = 1'b0;
                end else if (!serialReadActive) begin
                    st_nxt.busy[k] = 1'b0;
                    st_nxt.stable[k] = lvl[k];
                    if (!mask[k] && (lvl[k] || edgeSel[k])) begin
                        st_nxt.portIrq = 1'b1;
                    end
                end
            end
        end
        // Shared copy; duty latched at cycle start.
        for (k = 0; k < 4; k++) begin
            if (pwmStart) begin
                if (st_r.ledCfg[k][`GLPC_B_SHARED]) begin
                    st_nxt.indiv[k] = st_r.shared;
                end
                case (st_r.fMode[k])
                    glpc_pkg::FADE_IN:  st_nxt.duty[k] = scale(st_r.indiv[k], st_r.fStep[k]);
                    glpc_pkg::FADE_OUT: st_nxt.duty[k] =
                        scale(st_r.fBase[k], `GLPC_FADE_STEPS - st_r.fStep[k]);
                    default:            st_nxt.duty[k] = st_r.dark[k] ? 8'h00 : st_r.indiv[k];
                endcase
            end
            if (fadeTick && st_r.fMode[k] != glpc_pkg::FADE_NONE) begin
                st_nxt.fStep[k] = st_r.fStep[k] + 5'h01;
                if (st_nxt.fStep[k] == `GLPC_FADE_STEPS) begin
                    st_nxt.dark[k] = st_r.fMode[k] == glpc_pkg::FADE_OUT;
                    st_nxt.fMode[k] = glpc_pkg::FADE_NONE;
                end
            end
            // Sleep, wake, or shared value to or from zero.
            trigOut = sleepNow;
            trigIn = wake;
            if (regWrEn && regAddr == `GLPC_A_SHARED && st_r.ledCfg[k][`GLPC_B_SHARED]) begin
                trigOut = trigOut | (st_r.shared != 8'h00 && regWrData == 8'h00);
                trigIn = trigIn | (st_r.shared == 8'h00 && regWrData != 8'h00);
            end
            if (trigIn) begin
                st_nxt.dark[k] = 1'b0;
                if (st_r.gctl[2:0] != 3'h0) begin
                    st_nxt.fMode[k] = glpc_pkg::FADE_IN;
                    st_nxt.fStep[k] = 5'h00;
                end
            end else if (trigOut) begin
                if (st_r.gctl[2:0] != 3'h0) begin
                    st_nxt.fMode[k] = glpc_pkg::FADE_OUT;
                    st_nxt.fStep[k] = 5'h00;
                    st_nxt.fBase[k] = st_r.duty[k];
                end else begin
                    st_nxt.dark[k] = 1'b1;
                end
            end
        end
        // Register writes.
        if (regWrEn) begin
            case (regAddr)
                `GLPC_A_LEDEN:  st_nxt.ledEn = regWrData[3:0];
                `GLPC_A_ROWDIR: st_nxt.rowDir = regWrData;
                `GLPC_A_COLDIR: st_nxt.colDir = regWrData;
                `GLPC_A_ROWDRV: st_nxt.rowDrv = regWrData;
                `GLPC_A_COLDRV: st_nxt.colDrv = regWrData;
                `GLPC_A_ROWREF: st_nxt.rowRef = regWrData;
                `GLPC_A_COLREF: st_nxt.colRef = regWrData;
                `GLPC_A_ROWVAL: st_nxt.outVal[7:0] = regWrData;
                `GLPC_A_COLVAL: st_nxt.outVal[15:8] = regWrData;
                `GLPC_A_XLATE:  st_nxt.xlate = regWrData;
                `GLPC_A_GCTL:   st_nxt.gctl = {regWrData[5:4], 1'b0, regWrData[2:0]};
                `GLPC_A_DBNC:   st_nxt.dbSel = regWrData[4:0];
                `GLPC_A_SINK:   st_nxt.sinkSel = regWrData[0];
                `GLPC_A_SHARED: st_nxt.shared = regWrData;
                `GLPC_A_ROWMSK: st_nxt.rowMask = regWrData;
                `GLPC_A_COLMSK: st_nxt.colMask = regWrData;
                `GLPC_A_ROWEDG: st_nxt.rowEdge = regWrData;
                `GLPC_A_COLEDG: st_nxt.colEdge = regWrData;
                default: begin
                end
            endcase
            for (k = 0; k < 4; k++) begin
                if (regAddr == `GLPC_A_INT4 + 8'(k)) begin
                    st_nxt.indiv[k] = regWrData;
                    if (st_r.fMode[k] == glpc_pkg::FADE_IN) begin
                        st_nxt.duty[k] = regWrData;
                    end else if (st_r.fMode[k] == glpc_pkg::FADE_OUT) begin
                        st_nxt.duty[k] = 8'h00;
                    end
                    st_nxt.dark[k] = st_r.fMode[k] == glpc_pkg::FADE_OUT;
                    st_nxt.fMode[k] = glpc_pkg::FADE_NONE;
                end
                if (regAddr == `GLPC_A_CFG4 + 8'(k)) begin
                    st_nxt.ledCfg[k] = regWrData[5:0];
                end
            end
            // Soft reset of the port and LED set.
            if (regAddr == `GLPC_A_GCTL && regWrData[`GLPC_B_SRST]) begin
                st_nxt.ledEn = 4'h0;
                {st_nxt.rowDir, st_nxt.colDir, st_nxt.rowDrv, st_nxt.colDrv} = '0;
                {st_nxt.rowRef, st_nxt.colRef, st_nxt.xlate, st_nxt.shared} = '0;
                {st_nxt.rowMask, st_nxt.colMask, st_nxt.rowEdge, st_nxt.colEdge} = '0;
                st_nxt.gctl = 6'(`GLPC_RST_REG);
                st_nxt.dbSel = 5'h00;
                st_nxt.sinkSel = 1'b0;
                st_nxt.outVal = 16'h0000;
                st_nxt.indiv = '0;
                st_nxt.ledCfg = '0;
            end
        end
        // Read data; outputs read as zero.
        if (regRdEn) begin
            case (regAddr)
                `GLPC_A_LEDEN:  st_nxt.rdData = {4'h0, st_r.ledEn};
                `GLPC_A_ROWDIR: st_nxt.rdData = st_r.rowDir;
                `GLPC_A_COLDIR: st_nxt.rdData = st_r.colDir;
                `GLPC_A_ROWDRV: st_nxt.rdData = st_r.rowDrv;
                `GLPC_A_COLDRV: st_nxt.rdData = st_r.colDrv;
                `GLPC_A_ROWREF: st_nxt.rdData = st_r.rowRef;
                `GLPC_A_COLREF: st_nxt.rdData = st_r.colRef;
                `GLPC_A_ROWVAL: st_nxt.rdData = st_r.stable[7:0] & ~isOut[7:0];
                `GLPC_A_COLVAL: st_nxt.rdData = st_r.stable[15:8] & ~isOut[15:8];
                `GLPC_A_XLATE:  st_nxt.rdData = st_r.xlate;
                `GLPC_A_GCTL:   st_nxt.rdData = {2'h0, st_r.gctl};
                `GLPC_A_DBNC:   st_nxt.rdData = {3'h0, st_r.dbSel};
                `GLPC_A_SINK:   st_nxt.rdData = {7'h00, st_r.sinkSel};
                `GLPC_A_SHARED: st_nxt.rdData = st_r.shared;
                `GLPC_A_TOFLAG: st_nxt.rdData = {7'h00, st_r.toFlag};
                `GLPC_A_ROWMSK: st_nxt.rdData = st_r.rowMask;
                `GLPC_A_COLMSK: st_nxt.rdData = st_r.colMask;
                `GLPC_A_ROWEDG: st_nxt.rdData = st_r.rowEdge;
                `GLPC_A_COLEDG: st_nxt.rdData = st_r.colEdge;
                default:        st_nxt.rdData = 8'h00;
            endcase
            for (k = 0; k < 4; k++) begin
                if (regAddr == `GLPC_A_INT4 + 8'(k)) begin
                    st_nxt.rdData = st_r.indiv[k];
                end
                if (regAddr == `GLPC_A_CFG4 + 8'(k)) begin
                    st_nxt.rdData = {2'h0, st_r.ledCfg[k]};
                end
            end
        end
        for (k = 0; k < 16; k++) begin
            rdVal = 1'b1;
            if (!gEn) begin
                rdVal = 1'b1;
            end else if (isOut[k]) begin
                rdVal = drv[k] ? 1'b0 : drvVal[k];
            end
            if (k < 8) begin
                st_nxt.rowOut[k] = gEn & isOut[k] & drv[k] & drvVal[k];
                st_nxt.rowOeN[k] = rdVal;
            end else begin
                st_nxt.colOut[k - 8] = gEn & isOut[k] & drv[k] & drvVal[k];
                st_nxt.colOeN[k - 8] = rdVal;
            end
        end
        for (k = 0; k < 4; k++) begin
            bSh = (st_r.ledCfg[k][4:2] > 3'h5) ? 3'h4 : st_r.ledCfg[k][4:2] - 3'h1;
            per = `GLPC_BLINK_MS << bSh;
            phase = st_r.blinkCnt & 12'(per - 13'h0001);
            onLen = per >> ({1'b0, st_r.ledCfg[k][1:0]} + 3'h1);
            blinkOn = (st_r.ledCfg[k][4:2] == 3'h0) || ({1'b0, phase} < onLen);
            sinkOn = (st_r.duty[k] == 8'hFF) || (st_r.pwmCnt < st_r.duty[k]);
            if (gEn && st_r.ledEn[k]) begin
                st_nxt.colOut[k + 4] = 1'b0;
                st_nxt.colOeN[k + 4] = ~(sinkOn & blinkOn);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.rowOeN <= 8'hFF;
            st_r.colOeN <= 8'hFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign sleepActive = st_r.asleep;
    assign rowOut = st_r.rowOut;
    assign rowOe_n = st_r.rowOeN;
    assign colOut = st_r.colOut;
    assign colOe_n = st_r.colOeN;
    assign rowRefAlt = st_r.rowRef;
    assign colRefAlt = st_r.colRef;
    assign sinkHigh = st_r.sinkSel;
    assign interruptReq = st_r.portIrq | (st_r.toFlag & st_r.gctl[`GLPC_B_TOIE]);
endmodule

// File: tb/glpc_core_props.sv
/* Port checker of glpc_core, bound to every instance.
   Assumes one clock ref_clk and the active-high asynchronous reset rst. */
`timescale 1ns/1ps
module glpc_core_props (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       busTimeout,
    input wire logic       sleepActive,
    input wire logic [7:0] rowOut,
    input wire logic [7:0] rowOe_n,
    input wire logic [7:0] rowRefAlt,
    input wire logic       sinkHigh,
    input wire logic       interruptReq
);
    logic [7:0] drvR;
    logic [7:0] dirR;
    logic [1:0] gctlR;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drvR <= 8'h00;
            dirR <= 8'h00;
            gctlR <= 2'h0;
        end else if (regWrEn) begin
            if (regAddr == 8'h36) drvR <= regWrData;
            if (regAddr == 8'h34) dirR <= regWrData;
            if (regAddr == 8'h40) gctlR <= regWrData[3] ? 2'h0 : regWrData[5:4];
            if (regAddr == 8'h40 && regWrData[3]) {drvR, dirR} <= 16'h0000;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_timeout;
        busTimeout && !sleepActive;
    endsequence
    sequence s_flagRead;
        regRdEn && regAddr == 8'h48;
    endsequence
    a_open_drain: assert property (1'b1 |=> (rowOut & ~$past(drvR)) == 8'h00)
        else $error("open-drain row drives high");
    a_ref_follows: assert property (regWrEn && regAddr == 8'h38 ##1 !regWrEn
        |=> rowRefAlt == $past(regWrData, 2))
        else $error("row reference select wrong");
    a_out_reads_zero: assert property (regRdEn && regAddr == 8'h3A
        |=> (regRdData & $past(dirR)) == 8'h00)
        else $error("output row read nonzero");
    a_ports_off: assert property (!gctlR[0] |=> rowOe_n == 8'hFF)
        else $error("row driven while ports disabled");
    a_sink_follows: assert property (regWrEn && regAddr == 8'h43 ##1 !regWrEn
        |=> sinkHigh == $past(regWrData[0], 2))
        else $error("sink select wrong");
    a_flag_read: assert property (s_timeout ##1 s_flagRead |=> regRdData == 8'h01)
        else $error("timeout flag not read as set");
    a_timeout_irq: assert property ((s_timeout and (gctlR[1] && !regWrEn))
        |=> interruptReq)
        else $error("timeout interrupt missing");
    a_irq_holds: assert property (interruptReq && !regWrEn
        && !(regRdEn && regAddr inside {8'h3A, 8'h3B, 8'h48}) |=> interruptReq)
        else $error("interrupt dropped without read");
    a_rd_holds: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without read");
    a_sleep_refused: assert property (gctlR[0] && $past(gctlR[0]) |-> !sleepActive)
        else $error("sleep while ports enabled");
endmodule
bind glpc_core glpc_core_props u_props (.*);

// File: tb/glpc_host_model.sv
/* Host side of the register port: byte reads and writes on ref_clk.
   Assumes the core takes strobes at the rising edge and answers a cycle later. */
`timescale 1ns/1ps
module glpc_host_model (
    input wire logic       ref_clk,
    input wire logic [7:0] regRdData,
    output logic     [7:0] regAddr,
    output logic           regWrEn,
    output logic     [7:0] regWrData,
    output logic           regRdEn,
    output logic           serialReadActive
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
        serialReadActive = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        serialReadActive <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(posedge ref_clk);
        d = regRdData;
        serialReadActive <= 1'b0;
    endtask
endmodule

// File: tb/glpc_core_tb.sv
/* Self-checking bench of glpc_core with the host model and a shadow register model.
   Assumes shortened timing: four cycles per millisecond, one cycle per PWM step. */
`timescale 1ns/1ps
module glpc_core_tb;
    logic [7:0] regAddr, regWrData, regRdData, rowIn, colIn, rowOut, rowOe_n, rd;
    logic       regWrEn, regRdEn, serialReadActive, busTimeout, sleepRequest;
    logic       sleepActive, interruptReq, seen;
    logic [7:0] colOut, colOe_n;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    logic [31:0] seed = 32'h0194;
    int         n_mismatch = 0;
    int         checked = 0;
    logic [7:0] addrQ[$] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3C, 8'h40, 8'h42, 8'h43, 8'h45,
        8'h50, 8'h53, 8'h54, 8'h57, 8'h58, 8'h59, 8'h5A, 8'h5B};
    logic [7:0] maskQ[$] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h27, 8'h1F, 8'h01, 8'hFF,
        8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] expQ[$];
    always #20 ref_clk = ~ref_clk;
    glpc_host_model host (.ref_clk(ref_clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .serialReadActive(serialReadActive));
    glpc_core #(.CYC_PER_MS(4), .PWM_STEP_CYC(8'h01)) dut (.ref_clk(ref_clk), .rst(rst),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .serialReadActive(serialReadActive), .busTimeout(busTimeout),
        .sleepRequest(sleepRequest), .sleepActive(sleepActive), .rowIn(rowIn), .colIn(colIn),
        .rowOut(rowOut), .rowOe_n(rowOe_n), .colOut(colOut), .colOe_n(colOe_n),
        .rowRefAlt(),
        .colRefAlt(), .sinkHigh(), .interruptReq(interruptReq));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        host.rd(a, rd);
        check(what, exp, rd);
    endtask
    task automatic waitIrq(input int lim);
        seen = 1'b0;
        repeat (lim) @(posedge ref_clk) if (interruptReq === 1'b1) seen = 1'b1;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        n_mismatch++;
        summarize();
    end
    initial begin
        {rowIn, colIn, busTimeout, sleepRequest} = '0;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (addrQ[i]) rdChk(addrQ[i], 8'h00, "reset value");
        rdChk(8'h70, 8'h00, "unmapped read");
        foreach (addrQ[i]) begin
            seed = xs(seed);
            expQ.push_back(seed[7:0] & maskQ[i]);
            host.wr(addrQ[i], expQ[i]);
        end
        foreach (addrQ[i]) rdChk(addrQ[i], expQ[i], "readback");
        foreach (addrQ[i]) host.wr(addrQ[i], 8'h00);
        host.wr(8'h48, 8'hFF);
        rdChk(8'h48, 8'h00, "read-only flag");
        host.wr(8'h40, 8'h20);
        @(posedge ref_clk) busTimeout <= 1'b1;
        fork
            host.rd(8'h48, rd);
            @(posedge ref_clk) busTimeout <= 1'b0;
        join
        check("timeout flag", 8'h01, rd);
        check("irq after flag read", 8'h00, {7'h0, interruptReq});
        host.wr(8'h40, 8'h10);
        host.wr(8'h58, 8'h02);
        host.wr(8'h59, 8'hFF);
        colIn <= seed[15:8];
        repeat (80) @(posedge ref_clk);
        rdChk(8'h3B, seed[15:8], "column inputs");
        rowIn <= 8'h01;
        waitIrq(80);
        check("rising event irq", 8'h01, {7'h0, seen});
        rdChk(8'h3A, 8'h01, "row values");
        check("irq cleared", 8'h00, {7'h0, interruptReq});
        rowIn <= 8'h03;
        waitIrq(80);
        check("masked event irq", 8'h00, {7'h0, seen});
        rowIn <= 8'h02;
        waitIrq(80);
        check("falling edge rising mode", 8'h00, {7'h0, seen});
        host.wr(8'h5A, 8'h01);
        rowIn <= 8'h03;
        repeat (80) @(posedge ref_clk);
        rdChk(8'h3A, 8'h03, "row values");
        rowIn <= 8'h02;
        waitIrq(80);
        check("both edges irq", 8'h01, {7'h0, seen});
        rdChk(8'h3A, 8'h02, "row values");
        host.wr(8'h34, 8'hFF);
        host.wr(8'h36, 8'h0F);
        host.wr(8'h3A, 8'h55);
        repeat (3) @(posedge ref_clk);
        check("row outputs", 8'h05, rowOut);
        check("row enables", 8'h50, rowOe_n);
        rdChk(8'h3A, 8'h00, "output reads zero");
        host.wr(8'h54, 8'h20);
        host.wr(8'h45, 8'h80);
        host.wr(8'h51, 8'hFF);
        host.wr(8'h31, 8'h02);
        repeat (600) @(posedge ref_clk);
        rdChk(8'h50, 8'h80, "shared copy");
        check("LED pins", 8'h0D, {colOut[7:4], colOe_n[7:4]});
        host.wr(8'h31, 8'h00);
        sleepRequest <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check("sleep refused", 8'h00, {7'h0, sleepActive});
        host.wr(8'h40, 8'h00);
        repeat (5) @(posedge ref_clk);
        check("sleep granted", 8'h01, {7'h0, sleepActive});
        summarize();
    end
endmodule
